//--- pkg/ext_bus_pkg.sv
// Purpose: constants and types shared by the page-mode external bus design
// Assumes: one system clock equals one clk_en_in tick of clk_in
// Notes: all lengths are counted in system clocks
package ext_bus_pkg;

  localparam int ADDRESS_CONTROL_REG_PME_BIT = 7;
  localparam int ADDRESS_CONTROL_REG_PS_MSB = 6;
  localparam int ADDRESS_CONTROL_REG_PS_LSB = 5;
  localparam logic [7:0] ADDRESS_CONTROL_REG_RESET = 8'h00;

  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [3:0] TA_WINDOW_CLK = 4'h3;

  localparam logic [5:0] HIT_CLK_PS0 = 6'h01;
  localparam logic [5:0] HIT_CLK_PS1 = 6'h02;
  localparam logic [5:0] HIT_CLK_PS2 = 6'h04;
  localparam logic [5:0] STROBE_NARROW = 6'h01;
  localparam logic [5:0] STROBE_WIDE = 6'h02;
  localparam logic [5:0] PM2_MISS_LATCH = 6'h02;
  localparam logic [5:0] PM2_FETCH_SETUP = 6'h01;
  localparam logic [5:0] PM2_FETCH_STROBE = 6'h01;
  localparam logic [5:0] BASIC_LATCH = 6'h01;
  localparam logic [5:0] BASIC_SETUP = 6'h01;
  localparam logic [5:0] BASIC_STROBE = 6'h02;
  localparam logic [5:0] STRETCH_CLK = 6'h04;
  localparam logic [5:0] STRETCH_LONG_SPLIT = 6'h0C;
  localparam logic [3:0] STRETCH_LONG_OFFS = 4'h3;
  localparam logic [3:0] STRETCH_LONG_MIN = 4'h7;

  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } acc_kind_t;

  typedef enum logic [1:0] {
    PS_ONE = 2'b00,
    PS_TWO = 2'b01,
    PS_FOUR = 2'b10,
    PS_MUX = 2'b11
  } page_sel_t;

  typedef enum logic [1:0] {
    BUS_NONPAGE = 2'b00,
    BUS_PAGE1 = 2'b01,
    BUS_PAGE2 = 2'b10
  } bus_mode_t;

  typedef enum logic [2:0] {
    SEG_IDLE = 3'b000,
    SEG_LATCH = 3'b001,
    SEG_SETUP = 3'b010,
    SEG_STROBE = 3'b011,
    SEG_HOLD = 3'b100
  } seg_t;

  typedef enum logic [1:0] {
    TA_LOCKED = 2'b00,
    TA_ARMED = 2'b01,
    TA_OPEN = 2'b10
  } ta_stage_t;

  typedef struct packed {
    acc_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] setup;
    logic [5:0] strobe;
    logic [5:0] hold;
  } seg_len_t;

  typedef struct packed {
    logic [7:0] port_zero_bus;
    logic port_zero_oe;
    logic [7:0] port_two_bus;
    logic port_two_oe;
    logic addr_latch_strobe;
    logic program_store_strobe_n;
    logic read_strobe_n;
    logic write_strobe_n;
  } ext_pins_t;

  typedef struct packed {
    ta_stage_t stage;
    logic [3:0] cnt;
  } ta_state_t;

  typedef struct packed {
    seg_t seg;
    logic [5:0] cnt;
    seg_len_t len;
    mem_req_t req;
    bus_mode_t mode;
    page_sel_t psel;
    logic [3:0] stretch_n;
    logic hit;
    logic [7:0] page;
    logic page_valid;
    logic after_data;
    logic page_en;
    page_sel_t page_sel;
    logic [7:0] rdata;
    logic done;
    logic ready;
    ext_pins_t pins;
  } ctl_state_t;

  localparam ext_pins_t PINS_IDLE = '{
    port_zero_bus: 8'h00, port_zero_oe: 1'b0,
    port_two_bus: 8'h00, port_two_oe: 1'b0,
    addr_latch_strobe: 1'b0, program_store_strobe_n: 1'b1,
    read_strobe_n: 1'b1, write_strobe_n: 1'b1};

  localparam ctl_state_t CTL_RESET = '{
    seg: SEG_IDLE, cnt: 6'h00, len: '0, req: '0,
    mode: BUS_NONPAGE, psel: PS_ONE, stretch_n: 4'h0, hit: 1'b0,
    page: 8'h00, page_valid: 1'b0, after_data: 1'b0,
    page_en: ADDRESS_CONTROL_REG_RESET[ADDRESS_CONTROL_REG_PME_BIT],
    page_sel: page_sel_t'(ADDRESS_CONTROL_REG_RESET[ADDRESS_CONTROL_REG_PS_MSB:ADDRESS_CONTROL_REG_PS_LSB]),
    rdata: 8'h00, done: 1'b0, ready: 1'b1, pins: PINS_IDLE};

endpackage

//--- design/timed_access_unlock.sv
// Purpose: two-key unlock window guarding protected register writes
// Assumes: key writes and consume are one-tick strobes qualified by clk_en_in
// Notes: a wrong second key relocks at once
`timescale 1ns/1ps
module timed_access_unlock
  import ext_bus_pkg::*;
#(
  parameter logic [3:0] WINDOW_CLK = TA_WINDOW_CLK
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_data_in,
  input wire logic consume_in,
  output logic open_out
);
  import ext_bus_pkg::*;

  ta_state_t q;
  ta_state_t d;

  always_comb
  begin
    d = q;
    case (q.stage)
      TA_LOCKED:
      begin
        if (key_wr_in && key_data_in == TA_KEY_FIRST)
        begin
          d.stage = TA_ARMED;
          d.cnt = WINDOW_CLK - 4'h1;
        end
      end
      TA_ARMED:
      begin
        if (key_wr_in)
        begin
          d.stage = (key_data_in == TA_KEY_SECOND) ? TA_OPEN : TA_LOCKED;
          d.cnt = WINDOW_CLK - 4'h1;
        end
        else if (q.cnt == 4'h0)
          d.stage = TA_LOCKED;
        else
          d.cnt = q.cnt - 4'h1;
      end
      TA_OPEN:
      begin
        // one protected write per unlock, then the gate shuts again
        if (consume_in || q.cnt == 4'h0)
          d.stage = TA_LOCKED;
        else
          d.cnt = q.cnt - 4'h1;
      end
      default:
        d.stage = TA_LOCKED;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      q <= '{stage: TA_LOCKED, cnt: 4'h0};
    else if (clk_en_in)
      q <= d;
  end

  assign open_out = (q.stage == TA_OPEN);

endmodule // timed_access_unlock

//--- design/page_mode_ext_memory_bus.sv
// Purpose: page-mode external memory bus sequencer for fetches and data
// Assumes: clk_en_in marks system clocks; pins are synchronous to clk_in
// Notes: one idle tick separates two accesses; config applies per access
`timescale 1ns/1ps
module page_mode_ext_memory_bus
  import ext_bus_pkg::*;
#(
  parameter logic [3:0] UNLOCK_WINDOW_CLK = TA_WINDOW_CLK
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic req_valid_in,
  input wire ext_bus_pkg::mem_req_t req_in,
  input wire logic [2:0] stretch_select_in,
  input wire logic key_wr_in,
  input wire logic [7:0] key_data_in,
  input wire logic address_control_reg_wr_in,
  input wire logic [7:0] address_control_reg_data_in,
  input wire logic [7:0] port_zero_in,
  input wire logic [7:0] port_two_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic page_hit_out,
  output logic page_mode_enable_out,
  output logic [1:0] page_select_out,
  output ext_bus_pkg::ext_pins_t ext_pins_out
);
  import ext_bus_pkg::*;
  if (UNLOCK_WINDOW_CLK < 4'h1)
  begin : g_bad_window
    $error("unlock window must be at least one clock");
  end
  logic [1:0] rst_sync_q;
  logic rst_n_sync;
  ctl_state_t q;
  ctl_state_t d;
  logic ta_open;
  logic ta_consume;
  logic accept;
  logic miss;
  bus_mode_t acc_mode;
  logic [3:0] stretch_n;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_sync);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_sync = rst_sync_q[1];
  timed_access_unlock #(
    .WINDOW_CLK(UNLOCK_WINDOW_CLK)
  ) u_unlock (
    .clk_in(clk_in),
    .rst_n_in(rst_n_sync),
    .clk_en_in(clk_en_in),
    .key_wr_in(key_wr_in),
    .key_data_in(key_data_in),
    .consume_in(ta_consume),
    .open_out(ta_open)
  );
  function automatic logic [5:0] hit_clocks(page_sel_t ps);
    case (ps)
      PS_ONE: hit_clocks = HIT_CLK_PS0;
      PS_TWO: hit_clocks = HIT_CLK_PS1;
      default: hit_clocks = HIT_CLK_PS2;
    endcase
  endfunction
  // segment lengths of one access; strobe is never empty
  function automatic seg_len_t calc_len(bus_mode_t m, page_sel_t ps,
                                        acc_kind_t k, logic mis,
                                        logic [3:0] n);
    seg_len_t l;
    logic [5:0] h;
    logic [5:0] sw;
    logic [5:0] ext;
    l = '0;
    h = hit_clocks(ps);
    sw = (h == HIT_CLK_PS2) ? STROBE_WIDE : STROBE_NARROW;
    ext = {n, 2'b00};
    if (m == BUS_PAGE1)
    begin
      l.latch = mis ? h : 6'h00;
      l.setup = h - sw;
      l.strobe = sw;
    end
    else if (m == BUS_PAGE2 && k == ACC_FETCH)
    begin
      l.latch = mis ? PM2_MISS_LATCH : 6'h00;
      l.setup = PM2_FETCH_SETUP;
      l.strobe = PM2_FETCH_STROBE;
    end
    else
    begin
      // plain bus timing: latch, turnaround, strobe = four clocks
      l.latch = BASIC_LATCH;
      l.setup = BASIC_SETUP;
      l.strobe = BASIC_STROBE;
    end
    if (k != ACC_FETCH && n != 4'h0)
    begin
      // a stretch below STRETCH_LONG_MIN spends one clock on setup and one on hold
      l.setup = l.setup + 6'h01;
      l.hold = 6'h01;
      l.strobe = l.strobe + ext - 6'h02;
      if (n >= STRETCH_LONG_MIN)
      begin
        if (l.latch != 6'h00)
          l.latch = l.latch + STRETCH_CLK;
        else
          l.setup = l.setup + STRETCH_CLK;
        l.setup = l.setup + STRETCH_CLK;
        l.hold = l.hold + STRETCH_CLK;
        l.strobe = l.strobe - STRETCH_LONG_SPLIT;
      end
    end
    return l;
  endfunction
  function automatic seg_t next_seg(seg_t cur, seg_len_t l);
    seg_t s;
    s = SEG_IDLE;
    case (cur)
      SEG_IDLE:
        s = (l.latch != 6'h00) ? SEG_LATCH :
            (l.setup != 6'h00) ? SEG_SETUP : SEG_STROBE;
      SEG_LATCH:
        s = (l.setup != 6'h00) ? SEG_SETUP : SEG_STROBE;
      SEG_SETUP:
        s = SEG_STROBE;
      SEG_STROBE:
        s = (l.hold != 6'h00) ? SEG_HOLD : SEG_IDLE;
      default:
        s = SEG_IDLE;
    endcase
    return s;
  endfunction
  function automatic logic [5:0] seg_cnt(seg_t s, seg_len_t l);
    case (s)
      SEG_LATCH: seg_cnt = l.latch - 6'h01;
      SEG_SETUP: seg_cnt = l.setup - 6'h01;
      SEG_STROBE: seg_cnt = l.strobe - 6'h01;
      SEG_HOLD: seg_cnt = l.hold - 6'h01;
      default: seg_cnt = 6'h00;
    endcase
  endfunction
  // pin levels belonging to a segment; registered with the state
  function automatic ext_pins_t drive_pins(ctl_state_t s);
    ext_pins_t p;
    logic strobe;
    logic wr;
    p = PINS_IDLE;
    strobe = (s.seg == SEG_STROBE);
    wr = (s.req.kind == ACC_WRITE);
    if (s.seg != SEG_IDLE)
    begin
      p.program_store_strobe_n = !(strobe && s.req.kind == ACC_FETCH);
      p.read_strobe_n = !(strobe && s.req.kind == ACC_READ);
      p.write_strobe_n = !(strobe && wr);
      p.addr_latch_strobe = (s.seg == SEG_LATCH);
      case (s.mode)
        BUS_PAGE1:
        begin
          p.port_two_oe = 1'b1;
          if (s.seg == SEG_LATCH)
            p.port_two_bus = s.req.addr[15:8];
          else
          begin
            p.port_two_bus = s.req.addr[7:0];
            p.port_zero_oe = wr;
            p.port_zero_bus = s.req.wdata;
          end
        end
        BUS_PAGE2:
        begin
          p.port_zero_oe = 1'b1;
          p.port_zero_bus = s.req.addr[7:0];
          p.port_two_oe = (s.seg == SEG_LATCH) || wr;
          p.port_two_bus = (s.seg == SEG_LATCH) ? s.req.addr[15:8]
                                                : s.req.wdata;
        end
        default:
        begin
          // plain expanded bus: low address then data on port zero
          p.port_two_oe = 1'b1;
          p.port_two_bus = s.req.addr[15:8];
          p.port_zero_oe = (s.seg == SEG_LATCH) || wr;
          p.port_zero_bus = (s.seg == SEG_LATCH) ? s.req.addr[7:0]
                                                 : s.req.wdata;
        end
      endcase
    end
    return p;
  endfunction
  assign accept = (q.seg == SEG_IDLE) && req_valid_in;
  assign stretch_n = stretch_select_in[2]
                     ? {1'b0, stretch_select_in} + STRETCH_LONG_OFFS
                     : {1'b0, stretch_select_in};
  always_comb
  begin
    acc_mode = BUS_NONPAGE;
    if (q.page_en)
      acc_mode = (q.page_sel == PS_MUX) ? BUS_PAGE2 : BUS_PAGE1;
    miss = !q.page_valid || (q.page != req_in.addr[15:8])
           || (q.page_sel == PS_ONE
               && (req_in.kind != ACC_FETCH || q.after_data));
  end
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    ta_consume = 1'b0;
    case (q.seg)
      SEG_IDLE:
      begin
        if (accept)
        begin
          d.req = req_in;
          d.mode = acc_mode;
          d.psel = q.page_sel;
          d.stretch_n = (req_in.kind == ACC_FETCH) ? 4'h0 : stretch_n;
          d.len = calc_len(acc_mode, q.page_sel, req_in.kind, miss,
                           d.stretch_n);
          d.hit = (acc_mode == BUS_PAGE1 && !miss)
                  || (acc_mode == BUS_PAGE2 && !miss
                      && req_in.kind == ACC_FETCH);
          d.after_data = (req_in.kind != ACC_FETCH);
          d.page = req_in.addr[15:8];
          d.page_valid = (acc_mode != BUS_NONPAGE);
          d.seg = next_seg(SEG_IDLE, d.len);
          d.cnt = seg_cnt(d.seg, d.len);
          d.ready = 1'b0;
        end
      end
      SEG_LATCH, SEG_SETUP, SEG_STROBE, SEG_HOLD:
      begin
        if (q.cnt != 6'h00)
          d.cnt = q.cnt - 6'h01;
        else
        begin
          // sampled on the edge where the strobe returns inactive
          if (q.seg == SEG_STROBE && q.req.kind != ACC_WRITE)
            d.rdata = (q.mode == BUS_PAGE2) ? port_two_in
                                            : port_zero_in;
          d.seg = next_seg(q.seg, q.len);
          d.cnt = seg_cnt(d.seg, q.len);
          if (d.seg == SEG_IDLE)
          begin
            d.done = 1'b1;
            d.ready = 1'b1;
          end
        end
      end
      default:
      begin
        d.seg = SEG_IDLE;
        d.ready = 1'b1;
      end
    endcase
    if (address_control_reg_wr_in && ta_open)
    begin
      ta_consume = 1'b1;
      d.page_en = address_control_reg_data_in[ADDRESS_CONTROL_REG_PME_BIT];
      d.page_sel = page_sel_t'(address_control_reg_data_in[ADDRESS_CONTROL_REG_PS_MSB:ADDRESS_CONTROL_REG_PS_LSB]);
      // a change of the page-enable bit wins over a page stored in the same tick
      if (d.page_en != q.page_en)
        d.page_valid = 1'b0;
    end
    d.pins = drive_pins(d);
  end
  always_ff @(posedge clk_in or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      q <= CTL_RESET;
    else if (clk_en_in)
      q <= d;
  end
  assign req_ready_out = q.ready;
  assign done_out = q.done;
  assign rdata_out = q.rdata;
  assign page_hit_out = q.hit;
  assign page_mode_enable_out = q.page_en;
  assign page_select_out = q.page_sel;
  assign ext_pins_out = q.pins;
  logic [6:0] acc_len_q;
  logic [6:0] exp_hit_len;
  logic [6:0] exp_data_len;
  always_ff @(posedge clk_in or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      acc_len_q <= 7'h00;
    else if (clk_en_in)
    begin
      if (q.seg != SEG_IDLE)
        acc_len_q <= acc_len_q + 7'h01;
      else if (accept)
        acc_len_q <= 7'h00;
    end
  end
  assign exp_hit_len = {1'b0, hit_clocks(q.psel)};
  assign exp_data_len = (q.hit ? exp_hit_len : {exp_hit_len[5:0], 1'b0})
                        + {1'b0, q.stretch_n, 2'b00};
  sequence s_fetch_done;
    q.done && q.mode == BUS_PAGE1 && q.req.kind == ACC_FETCH;
  endsequence
  sequence s_data_done;
    q.done && q.mode == BUS_PAGE1 && q.req.kind != ACC_FETCH;
  endsequence
  a_miss_length: assert property (
    s_fetch_done and !q.hit |-> acc_len_q == {exp_hit_len[5:0], 1'b0})
    else $error("page miss fetch has wrong length");
  a_hit_length: assert property (
    s_fetch_done and q.hit |-> acc_len_q == exp_hit_len)
    else $error("page hit fetch has wrong length");
  a_data_stretch_len: assert property (
    s_data_done |-> acc_len_q == exp_data_len)
    else $error("stretched data access has wrong length");
  a_mux_data_len: assert property (
    q.done && q.mode == BUS_PAGE2 && q.req.kind != ACC_FETCH
    && q.stretch_n == 4'h0 |-> acc_len_q == 7'h04)
    else $error("mode 2 data access is not four clocks");
  a_mux_fetch_len: assert property (
    q.done && q.mode == BUS_PAGE2 && q.req.kind == ACC_FETCH
    |-> acc_len_q == (q.hit ? 7'h02 : 7'h04))
    else $error("mode 2 fetch has wrong length");
  a_latch_quiet: assert property (
    q.pins.addr_latch_strobe && q.mode == BUS_PAGE1
    |-> q.pins.program_store_strobe_n && q.pins.read_strobe_n
        && q.pins.write_strobe_n && !q.pins.port_zero_oe
        && q.pins.port_two_bus == q.req.addr[15:8])
    else $error("latch phase drives strobes or wrong byte");
  a_hit_no_latch: assert property (
    q.hit && q.mode == BUS_PAGE1 && q.seg != SEG_IDLE
    |-> !q.pins.addr_latch_strobe
        && q.pins.port_two_bus == q.req.addr[7:0])
    else $error("page hit asserted latch strobe");
  a_fetch_float: assert property (
    q.mode == BUS_PAGE1 && q.seg != SEG_IDLE && q.req.kind != ACC_WRITE
    |-> !q.pins.port_zero_oe)
    else $error("port zero driven during fetch or read");
  a_write_drive: assert property (
    q.mode == BUS_PAGE1 && q.seg == SEG_STROBE && q.req.kind == ACC_WRITE
    |-> q.pins.port_zero_oe && q.pins.port_zero_bus == q.req.wdata
        && !q.pins.write_strobe_n)
    else $error("write data not driven under write strobe");
  a_forced_miss: assert property (
    accept && clk_en_in && acc_mode == BUS_PAGE1 && q.page_sel == PS_ONE
    && (req_in.kind != ACC_FETCH || q.after_data) |=> !q.hit)
    else $error("forced miss not applied");
  a_address_control_reg_locked: assert property (
    address_control_reg_wr_in && !ta_open && clk_en_in
    |=> $stable(q.page_en) && $stable(q.page_sel))
    else $error("locked control register changed");
  a_page_invalid: assert property (
    clk_en_in && address_control_reg_wr_in && ta_open
    && address_control_reg_data_in[ADDRESS_CONTROL_REG_PME_BIT] != q.page_en |=> !q.page_valid)
    else $error("page kept across mode change");
  a_page_stored: assert property (
    accept && clk_en_in && acc_mode != BUS_NONPAGE
    && !(address_control_reg_wr_in && ta_open)
    |=> q.page == $past(req_in.addr[15:8]) && q.page_valid)
    else $error("new page byte not stored");
endmodule // page_mode_ext_memory_bus

//--- test/ext_mem_model.sv
// Purpose: external memory with address latch for the bus bench
// Assumes: pins are registered, so they are stable between edges
// Notes: data is high byte xor low byte xor 5A; no write storage
`timescale 1ns/1ps
module ext_mem_model
  import ext_bus_pkg::*;
(
  input wire logic clk_in,
  input wire ext_bus_pkg::ext_pins_t pins_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_two_out
);
  logic [7:0] hi_q = 8'h00;
  logic [7:0] lo_q = 8'h00;
  logic lo_latched = 1'b0;
  logic [7:0] last_q = 8'h00;
  logic [7:0] lo;
  logic drive;
  logic [7:0] data;
  // plain bus latches its low byte off port zero; page mode 1 keeps
  // the low byte on port two for the rest of the cycle after the latch phase
  assign lo = pins_in.port_zero_oe ? pins_in.port_zero_bus
    : lo_latched ? lo_q : pins_in.port_two_bus;
  assign drive = !pins_in.program_store_strobe_n || !pins_in.read_strobe_n;
  assign data = hi_q ^ lo ^ 8'h5A;
  always_ff @(posedge clk_in)
  begin
    if (pins_in.addr_latch_strobe)
    begin
      hi_q <= pins_in.port_two_bus;
      lo_q <= pins_in.port_zero_bus;
      lo_latched <= pins_in.port_zero_oe;
    end
    if (drive)
      last_q <= data;
  end
  // a released bus shows the inverse so a late sample cannot match
  assign port_zero_out = drive ? data : ~last_q;
  assign port_two_out = port_zero_out;
endmodule // ext_mem_model

//--- test/tb.sv
// Purpose: self-checking bench for the page-mode external bus
// Assumes: clk_en_in held high, every clk_in edge is a system clock
// Notes: lengths are ticks from accept to done
`timescale 1ns/1ps
module tb;
  import ext_bus_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid_in = 1'b0;
  mem_req_t req_in = '0;
  logic [2:0] stretch_select_in = 3'h0;
  logic key_wr_in = 1'b0;
  logic [7:0] key_data_in = 8'h00;
  logic address_control_reg_wr_in = 1'b0;
  logic [7:0] address_control_reg_data_in = 8'h00;
  logic [7:0] port_zero_in;
  logic [7:0] port_two_in;
  logic [7:0] mem_zero;
  logic [7:0] mem_two;
  logic req_ready_out;
  logic done_out;
  logic [7:0] rdata_out;
  logic page_hit_out;
  logic page_mode_enable_out;
  logic [1:0] page_select_out;
  ext_pins_t ext_pins_out;
  int mismatches = 0;
  int n_checks = 0;

  always #10 clk_in = ~clk_in;

  assign port_zero_in = ext_pins_out.port_zero_oe
    ? ext_pins_out.port_zero_bus : mem_zero;
  assign port_two_in = ext_pins_out.port_two_oe
    ? ext_pins_out.port_two_bus : mem_two;

  page_mode_ext_memory_bus page_mode_ext_memory_bus_inst (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(1'b1),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .stretch_select_in(stretch_select_in),
    .key_wr_in(key_wr_in),
    .key_data_in(key_data_in),
    .address_control_reg_wr_in(address_control_reg_wr_in),
    .address_control_reg_data_in(address_control_reg_data_in),
    .port_zero_in(port_zero_in),
    .port_two_in(port_two_in),
    .req_ready_out(req_ready_out),
    .done_out(done_out),
    .rdata_out(rdata_out),
    .page_hit_out(page_hit_out),
    .page_mode_enable_out(page_mode_enable_out),
    .page_select_out(page_select_out),
    .ext_pins_out(ext_pins_out)
  );

  ext_mem_model ext_mem_model_inst (
    .clk_in(clk_in),
    .pins_in(ext_pins_out),
    .port_zero_out(mem_zero),
    .port_two_out(mem_two)
  );

  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  task automatic put(input logic [7:0] v, input logic address_control_reg);
    key_wr_in = !address_control_reg;
    address_control_reg_wr_in = address_control_reg;
    key_data_in = v;
    address_control_reg_data_in = v;
    tick();
  endtask

  // both strobes drop here in a step of their own; put drops key_wr_in in the step that raises address_control_reg_wr_in
  task automatic idle_cfg();
    key_wr_in = 1'b0;
    address_control_reg_wr_in = 1'b0;
    tick();
  endtask

  // unlocked write, then the control outputs must follow
  task automatic set_address_control_reg(input logic [7:0] v);
    put(TA_KEY_FIRST, 1'b0);
    put(TA_KEY_SECOND, 1'b0);
    put(v, 1'b1);
    idle_cfg();
    chk({5'h00, page_mode_enable_out, page_select_out}, {5'h00, v[7:5]});
  endtask

  task automatic refused_write();
    put(8'h00, 1'b1);
    idle_cfg();
    chk({5'h00, page_mode_enable_out, page_select_out}, 8'h05);
  endtask

  task automatic access(input acc_kind_t k, input logic [15:0] a,
    input logic [2:0] s, input int len, input logic hit);
    int n;
    n = 0;
    req_in = '{kind: k, addr: a, wdata: a[7:0]};
    stretch_select_in = s;
    req_valid_in = 1'b1;
    tick();
    req_valid_in = 1'b0;
    chk({7'h00, req_ready_out}, 8'h00);
    while (done_out !== 1'b1 && n < 60)
    begin
      tick();
      n++;
    end
    if (n >= 60)
    begin
      mismatches++;
      complete_run();
    end
    else
    begin
      chk(n[7:0], len[7:0]);
      chk({7'h00, req_ready_out}, 8'h01);
      chk({7'h00, page_hit_out}, {7'h00, hit});
      if (k != ACC_WRITE)
        chk(rdata_out, a[15:8] ^ a[7:0] ^ 8'h5A);
    end
  endtask

  initial
  begin
    repeat (16) tick();
    rst_n_in = 1'b1;
    repeat (3) tick();
    set_address_control_reg(8'hA0);
    refused_write();
    access(ACC_FETCH, 16'h1234, 3'h0, 4, 1'b0);
    access(ACC_FETCH, 16'h1256, 3'h0, 2, 1'b1);
    access(ACC_READ, 16'h1278, 3'h1, 6, 1'b1);
    access(ACC_READ, 16'h1278, 3'h4, 30, 1'b1);
    access(ACC_WRITE, 16'h1278, 3'h0, 2, 1'b1);
    set_address_control_reg(8'h80);
    access(ACC_READ, 16'h1290, 3'h0, 2, 1'b0);
    access(ACC_FETCH, 16'h12A0, 3'h0, 2, 1'b0);
    access(ACC_FETCH, 16'h12A1, 3'h0, 1, 1'b1);
    set_address_control_reg(8'hC0);
    access(ACC_FETCH, 16'h12B0, 3'h0, 4, 1'b1);
    access(ACC_FETCH, 16'h3400, 3'h0, 8, 1'b0);
    set_address_control_reg(8'hE0);
    access(ACC_READ, 16'h3412, 3'h0, 4, 1'b0);
    access(ACC_FETCH, 16'h3420, 3'h0, 2, 1'b1);
    access(ACC_FETCH, 16'h5600, 3'h0, 4, 1'b0);
    set_address_control_reg(8'h00);
    access(ACC_READ, 16'h3412, 3'h0, 4, 1'b0);
    complete_run();
  end
endmodule // tb
